// *** core/frt_pkg.sv ***
`default_nettype none
package frt_pkg;

  // ****************************************************
  // widths
  // ****************************************************
  localparam int unsigned CNT_W = 32;
  localparam int unsigned PSC_W = 8;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned MAX_CH = 4;

  // ****************************************************
  // register offsets
  // ****************************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL = 14'h0000;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 14'h0004;
  localparam logic [ADDR_W-1:0] OFS_MASK = 14'h0050;
  localparam logic [3:0] CH_GRP_FIRST = 4'h1;
  localparam logic [3:0] CH_CTRL = 4'h0;
  localparam logic [3:0] CH_FLAG = 4'h4;
  localparam logic [3:0] CH_CMP = 4'h8;

  // ****************************************************
  // field positions and reset values
  // ****************************************************
  localparam int unsigned CTRL_TEN_BIT = 0;
  localparam int unsigned CTRL_FRZ_BIT = 1;
  localparam int unsigned CTRL_CPS_LSB = 8;
  localparam int unsigned CH_EN_BIT = 0;
  localparam int unsigned CH_FLAG_BIT = 0;
  localparam logic [PSC_W-1:0] RST_CPS = 8'h00;
  localparam logic [CNT_W-1:0] RST_CNT = 32'h0000_0000;
  localparam logic [CNT_W-1:0] RST_CMP = 32'h0000_0000;

  // ****************************************************
  // bus answers
  // ****************************************************
  localparam logic [3:0] BE_FULL = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } frt_req_s;

  typedef struct packed {
    logic [PSC_W-1:0] counter_prescale_select;
    logic debug_halt_select;
    logic counter_run_enable;
  } frt_ctrl_s;

endpackage
`default_nettype wire

// *** core/frt_prescaler.sv ***
`default_nettype none
module frt_prescaler import frt_pkg::*; #(
  parameter int unsigned W = PSC_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [W-1:0] div,
  output logic tick
);

  // ****************************************************
  // divider
  // ****************************************************
  logic [W-1:0] div_cnt_q;

  if (W < 1) begin : g_chk
    $error("prescaler width must be at least one");
  end

  assign tick = run && (div_cnt_q >= div);

  always_ff @(posedge clk) begin
    if (srst || !run || tick) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  property p_div_one;
    @(posedge clk) disable iff (srst)
    run && div == '0 |-> tick;
  endproperty
  a_div_one: assert property (p_div_one)
    else $error("zero field does not divide by one");

  property p_div_two;
    @(posedge clk) disable iff (srst)
    tick && div == W'(1) ##1 run && div == W'(1) |->
      !tick ##1 (tick || !run || div != W'(1));
  endproperty
  a_div_two: assert property (p_div_two)
    else $error("divide by two spacing wrong");

endmodule
`default_nettype wire

// *** core/frt_channel.sv ***
`default_nettype none
module frt_channel import frt_pkg::*; #(
  parameter int unsigned W = CNT_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic en,
  input wire logic upd,
  input wire logic [W-1:0] cnt_nx,
  input wire logic [W-1:0] cmp,
  input wire logic clr,
  output logic flag_q
);

  // ****************************************************
  // match flag
  // ****************************************************
  logic hit;

  assign hit = en && upd && (cnt_nx == cmp);

  always_ff @(posedge clk) begin
    if (srst) begin
      flag_q <= 1'b0;
    end else if (hit) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  property p_flag_cause;
    @(posedge clk) disable iff (srst)
    !flag_q ##1 flag_q |-> $past(en) && $past(cnt_nx) == $past(cmp);
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("flag set without enabled exact match");

  property p_set_wins;
    @(posedge clk) disable iff (srst)
    hit && clr |=> flag_q;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("match lost against a clear");

endmodule
`default_nettype wire

// *** core/frt_timer.sv ***
`default_nettype none
module frt_timer import frt_pkg::*; #(
  parameter int unsigned N_CH = MAX_CH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic [1:0] avs_response,
  output logic avs_waitrequest,
  input wire logic debug_mode,
  output logic [N_CH-1:0] chan_irq,
  output logic irq
);

  // ****************************************************
  // parameter check
  // ****************************************************
  if (N_CH < 1 || N_CH > MAX_CH) begin : g_chk
    $error("channel count out of range");
  end

  // ****************************************************
  // state
  // ****************************************************
  frt_req_s req;
  frt_ctrl_s ctrl_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [N_CH-1:0] cen_q;
  logic [N_CH-1:0] mask_q;
  logic [N_CH-1:0] flags;
  logic [N_CH-1:0] clr;
  logic [CNT_W-1:0] cmp_q [N_CH];
  logic wait_q;
  logic [1:0] resp_q;
  logic [31:0] rdata_q;
  logic irq_q;
  logic run;
  logic tick;
  logic cnt_step;

  // ****************************************************
  // decode
  // ****************************************************
  logic [3:0] ch_grp;
  logic [3:0] ch_reg;
  logic [3:0] ch_idx;
  logic hit_ctrl;
  logic hit_count;
  logic hit_mask;
  logic ch_hit;
  logic any_hit;
  logic new_req;
  logic acc_wr;
  logic [1:0] resp_c;
  logic [31:0] rdata_c;

  assign req.rd = avs_read;
  assign req.wr = avs_write;
  assign req.addr = avs_address;
  assign req.be = avs_byteenable;
  assign req.wdata = avs_writedata;

  assign ch_grp = req.addr[7:4];
  assign ch_reg = req.addr[3:0];
  assign ch_idx = ch_grp - CH_GRP_FIRST;

  always_comb begin
    hit_ctrl = (req.addr == OFS_CTRL);
    hit_count = (req.addr == OFS_COUNT);
    hit_mask = (req.addr == OFS_MASK);
    ch_hit = (req.addr[ADDR_W-1:8] == '0);
    ch_hit = ch_hit && (ch_grp >= CH_GRP_FIRST);
    ch_hit = ch_hit && (ch_grp <= 4'(N_CH));
    ch_hit = ch_hit && (ch_reg == CH_CTRL || ch_reg == CH_FLAG ||
      ch_reg == CH_CMP);
    any_hit = hit_ctrl || hit_count || hit_mask || ch_hit;
  end

  always_comb begin
    if (req.be != BE_FULL) begin
      resp_c = RESP_SLVERR;
    end else if (!any_hit) begin
      resp_c = RESP_DECERR;
    end else begin
      resp_c = RESP_OKAY;
    end
  end

  assign new_req = (req.rd || req.wr) && wait_q;
  assign acc_wr = req.wr && !wait_q && (resp_q == RESP_OKAY);

  // ****************************************************
  // read mux
  // ****************************************************
  always_comb begin
    rdata_c = '0;
    if (resp_c != RESP_OKAY) begin
      rdata_c = '0;
    end else if (hit_ctrl) begin
      rdata_c[CTRL_TEN_BIT] = ctrl_q.counter_run_enable;
      rdata_c[CTRL_FRZ_BIT] = ctrl_q.debug_halt_select;
      rdata_c[CTRL_CPS_LSB +: PSC_W] = ctrl_q.counter_prescale_select;
    end else if (hit_count) begin
      rdata_c = cnt_q;
    end else if (hit_mask) begin
      rdata_c[N_CH-1:0] = mask_q;
    end else if (ch_reg == CH_CTRL) begin
      rdata_c[CH_EN_BIT] = cen_q[ch_idx[1:0]];
    end else if (ch_reg == CH_FLAG) begin
      rdata_c[CH_FLAG_BIT] = flags[ch_idx[1:0]];
    end else begin
      rdata_c = cmp_q[ch_idx[1:0]];
    end
  end

  // ****************************************************
  // bus handshake
  // ****************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      wait_q <= 1'b1;
      resp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else if (new_req) begin
      wait_q <= 1'b0;
      resp_q <= resp_c;
      rdata_q <= req.rd ? rdata_c : '0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_response = resp_q;
  assign avs_readdata = rdata_q;

  // ****************************************************
  // control register
  // ****************************************************
  // disabled out of reset
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q.counter_run_enable <= 1'b0;
      ctrl_q.debug_halt_select <= 1'b0;
      ctrl_q.counter_prescale_select <= RST_CPS;
    end else if (acc_wr && hit_ctrl) begin
      ctrl_q.counter_run_enable <= req.wdata[CTRL_TEN_BIT];
      ctrl_q.debug_halt_select <= req.wdata[CTRL_FRZ_BIT];
      ctrl_q.counter_prescale_select <= req.wdata[CTRL_CPS_LSB +: PSC_W];
    end
  end

  assign run = ctrl_q.counter_run_enable && !(ctrl_q.debug_halt_select && debug_mode);

  // ****************************************************
  // prescaler and counter
  // ****************************************************
  // field is ratio minus one
  frt_prescaler #(
    .W(PSC_W)
  ) u_psc (
    .clk(clk),
    .srst(srst),
    .run(run),
    .div(ctrl_q.counter_prescale_select),
    .tick(tick)
  );

  always_comb begin
    if (acc_wr && hit_count) begin
      cnt_d = req.wdata;
    end else if (tick) begin
      cnt_d = CNT_W'(cnt_q + 1'b1);
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= RST_CNT;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ****************************************************
  // channel registers
  // ****************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      cen_q <= '0;
      for (int i = 0; i < N_CH; i++) begin
        cmp_q[i] <= RST_CMP;
      end
    end else if (acc_wr && ch_hit) begin
      for (int i = 0; i < N_CH; i++) begin
        if (ch_idx == 4'(i) && ch_reg == CH_CTRL) begin
          cen_q[i] <= req.wdata[CH_EN_BIT];
        end
        if (ch_idx == 4'(i) && ch_reg == CH_CMP) begin
          cmp_q[i] <= req.wdata;
        end
      end
    end
  end

  // write one to clear a flag
  always_comb begin
    for (int i = 0; i < N_CH; i++) begin
      clr[i] = acc_wr && ch_hit && ch_reg == CH_FLAG &&
        ch_idx == 4'(i) && req.wdata[CH_FLAG_BIT];
    end
  end

  // count load suppresses a match
  assign cnt_step = tick && !(acc_wr && hit_count);

  for (genvar gi = 0; gi < N_CH; gi++) begin : g_ch
    frt_channel #(
      .W(CNT_W)
    ) u_ch (
      .clk(clk),
      .srst(srst),
      .en(cen_q[gi]),
      .upd(cnt_step),
      .cnt_nx(cnt_d),
      .cmp(cmp_q[gi]),
      .clr(clr[gi]),
      .flag_q(flags[gi])
    );

    property p_chan_sep;
      @(posedge clk) disable iff (srst)
      !flags[gi] ##1 flags[gi] |-> $past(tick) &&
        $past(cen_q[gi]) && cnt_q == $past(cmp_q[gi]);
    endproperty
    a_chan_sep: assert property (p_chan_sep)
      else $error("channel request without its own match");
  end

  assign chan_irq = flags;

  // ****************************************************
  // interrupt mask and summary
  // ****************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      mask_q <= '0;
    end else if (acc_wr && hit_mask) begin
      mask_q <= req.wdata[N_CH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags & mask_q);
    end
  end

  assign irq = irq_q;

  // ****************************************************
  // checks
  // ****************************************************
  property p_run_hold;
    @(posedge clk) disable iff (srst)
    !run && !(acc_wr && hit_count) |=> $stable(cnt_q);
  endproperty
  a_run_hold: assert property (p_run_hold)
    else $error("counter moved while not running");

  property p_count_step;
    @(posedge clk) disable iff (srst)
    tick && !(acc_wr && hit_count) |=>
      cnt_q == CNT_W'($past(cnt_q) + 1'b1);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not advance by one");

  property p_no_stop;
    @(posedge clk) disable iff (srst)
    run && ctrl_q.counter_prescale_select == '0 && !(acc_wr && hit_count) |=>
      cnt_q != $past(cnt_q);
  endproperty
  a_no_stop: assert property (p_no_stop)
    else $error("counter stalled while running undivided");

  property p_wrap;
    @(posedge clk) disable iff (srst)
    tick && cnt_q == '1 && !(acc_wr && hit_count) |=> cnt_q == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap to zero");

  property p_dbg_halt;
    @(posedge clk) disable iff (srst)
    debug_mode && ctrl_q.debug_halt_select |-> !tick;
  endproperty
  a_dbg_halt: assert property (p_dbg_halt)
    else $error("counter ticked while frozen");

  property p_size_err;
    @(posedge clk) disable iff (srst)
    new_req && req.be != BE_FULL |=>
      !avs_waitrequest && avs_response == RESP_SLVERR;
  endproperty
  a_size_err: assert property (p_size_err)
    else $error("partial access not answered with error");

  property p_read_count;
    @(posedge clk) disable iff (srst)
    new_req && req.rd && hit_count && req.be == BE_FULL |=>
      avs_readdata == $past(cnt_q) ##1 avs_waitrequest;
  endproperty
  a_read_count: assert property (p_read_count)
    else $error("count read returned wrong value");

  property p_irq_level;
    @(posedge clk) disable iff (srst)
    |(flags & mask_q) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt missing for unmasked flag");

endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
module testbench import frt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // stimulus
  // ****************
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = BE_FULL;
  logic [31:0] avs_writedata = '0;
  logic debug_mode = 1'b0;
  logic [31:0] avs_readdata;
  logic [1:0] avs_response;
  logic avs_waitrequest;
  logic [3:0] chan_irq;
  logic irq;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  frt_timer #(.N_CH(4)) dut_u (.clk(clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
    .debug_mode(debug_mode), .chan_irq(chan_irq), .irq(irq));
  // ****************
  // checks and bus
  // ****************
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      $display("unexpected %0t timeout", $time);
      tally_and_finish();
    end
  end
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("unexpected %0t word %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("unexpected %0t resp %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_line(input logic [4:0] e);
    @(posedge clk);
    @(negedge clk);
    n_compared++;
    if ({irq, chan_irq} !== e) begin
      fails++;
      $display("unexpected %0t irq %b want %b", $time, {irq, chan_irq}, e);
    end
    @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [13:0] a, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b1, a, BE_FULL, d, q, r);
    chk_resp(r, RESP_OKAY);
  endtask
  task automatic rd(input logic [13:0] a, output logic [31:0] q);
    logic [1:0] r;
    bus(1'b0, a, BE_FULL, '0, q, r);
    chk_resp(r, RESP_OKAY);
  endtask
  function automatic logic [13:0] cha(input int i, input logic [3:0] o);
    return 14'(16 * (i + 1)) + 14'(o);
  endfunction
  // two count reads whose taking edges lie n cycles apart
  task automatic span(input int n, output logic [31:0] a,
      output logic [31:0] b);
    rd(OFS_COUNT, a);
    repeat (n - 3) @(posedge clk);
    rd(OFS_COUNT, b);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    logic [31:0] q;
    rd(OFS_CTRL, q);
    chk_word(q, 32'h0000_0000);
    rd(OFS_MASK, q);
    chk_word(q, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      rd(cha(i, CH_CTRL), q);
      chk_word(q, 32'h0000_0000);
      rd(cha(i, CH_FLAG), q);
      chk_word(q, 32'h0000_0000);
      rd(cha(i, CH_CMP), q);
      chk_word(q, RST_CMP);
    end
    rd(OFS_COUNT, q);
    chk_word(q, RST_CNT);
    chk_line(5'h00);
    $display("test reset done");
  endtask
  task automatic t_rate();
    logic [7:0] counter_prescale_select [4] = '{8'h00, 8'h01, 8'h03, 8'hFF};
    int m [4] = '{20, 10, 10, 2};
    logic [31:0] a;
    logic [31:0] b;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, {16'h0000, counter_prescale_select[i], 8'h01});
      span((int'(counter_prescale_select[i]) + 1) * m[i], a, b);
      chk_word(b - a, 32'(m[i]));
    end
    $display("test rate done");
  endtask
  task automatic t_wrap();
    logic [31:0] a;
    logic [31:0] b;
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_COUNT, 32'hFFFF_FFF0);
    span(12, a, b);
    chk_word(b, 32'hFFFF_FFF0);
    wr(OFS_CTRL, 32'h0000_0001);
    span(30, a, b);
    chk_word(b - a, 32'h0000_001E);
    chk_word({31'h0, b < a}, 32'h0000_0001);
    $display("test wrap done");
  endtask
  task automatic t_debug();
    logic [31:0] a;
    logic [31:0] b;
    wr(OFS_CTRL, 32'h0000_0003);
    debug_mode <= 1'b1;
    span(10, a, b);
    chk_word(b - a, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    span(10, a, b);
    chk_word(b - a, 32'h0000_000A);
    wr(OFS_CTRL, 32'h0000_0003);
    debug_mode <= 1'b0;
    span(10, a, b);
    chk_word(b - a, 32'h0000_000A);
    $display("test debug done");
  endtask
  task automatic t_chan();
    logic [31:0] q;
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_COUNT, 32'hABCD_0000);
    for (int i = 0; i < 4; i++) begin
      q = 32'hABCD_0014 + 32'(10 * i);
      wr(cha(i, CH_CMP), (i == 2) ? {1'b0, q[30:0]} : q);
      wr(cha(i, CH_CTRL), {31'h0, i != 3});
    end
    wr(OFS_MASK, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    repeat (100) @(posedge clk);
    chk_line(5'h03);
    rd(cha(0, CH_FLAG), q);
    chk_word(q, 32'h0000_0001);
    rd(cha(3, CH_FLAG), q);
    chk_word(q, 32'h0000_0000);
    wr(OFS_MASK, 32'h0000_0001);
    chk_line(5'h13);
    wr(cha(0, CH_FLAG), 32'h0000_0001);
    chk_line(5'h02);
    wr(OFS_MASK, 32'h0000_0002);
    chk_line(5'h12);
    wr(cha(1, CH_FLAG), 32'h0000_0001);
    chk_line(5'h00);
    // match lands in the clear's answer cycle
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_COUNT, 32'h0000_1000);
    wr(cha(0, CH_CMP), 32'h0000_1003);
    wr(OFS_CTRL, 32'h0000_0001);
    wr(cha(0, CH_FLAG), 32'h0000_0001);
    rd(cha(0, CH_FLAG), q);
    chk_word(q, 32'h0000_0001);
    wr(cha(0, CH_FLAG), 32'h0000_0001);
    rd(cha(0, CH_FLAG), q);
    chk_word(q, 32'h0000_0000);
    $display("test channels done");
  endtask
  task automatic t_err();
    logic [13:0] bad [6] = '{14'h0008, 14'h000C, 14'h001C, 14'h0054,
      14'h0002, 14'h3FFC};
    logic [31:0] q;
    logic [1:0] r;
    wr(OFS_CTRL, 32'h0000_0000);
    bus(1'b1, OFS_CTRL, 4'h3, 32'h0000_0001, q, r);
    chk_resp(r, RESP_SLVERR);
    bus(1'b0, OFS_CTRL, 4'hC, '0, q, r);
    chk_resp(r, RESP_SLVERR);
    rd(OFS_CTRL, q);
    chk_word(q, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, bad[i], BE_FULL, 32'hFFFF_FFFF, q, r);
      chk_resp(r, RESP_DECERR);
      bus(1'b0, bad[i], BE_FULL, '0, q, r);
      chk_resp(r, RESP_DECERR);
      chk_word(q, 32'h0000_0000);
    end
    $display("test errors done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_rate();
    t_wrap();
    t_debug();
    t_chan();
    t_err();
    tally_and_finish();
  end
endmodule
`default_nettype wire
